// ### core/cmsr_params.svh
// Purpose: constants of the serial configuration read-out block
// Assumes: 8-Mbit array; the smaller part halves every span
// Notes:   addresses count bits, one per serial clock
`ifndef CMSR_PARAMS_SVH
`define CMSR_PARAMS_SVH
`define CMSR_ADDR_W        23
`define CMSR_MEM_DEPTH     64
`define CMSR_MEM_IDX_W     6
`define CMSR_FULL_LAST     23'h7FFFFF
`define CMSR_PAGE_SHIFT    21
`define CMSR_PAGE_LAST     23'h1FFFFF
`define CMSR_POR_CYCLES    8
`define CMSR_POR_W         4
`endif

// ### core/cmsr_pkg.sv
// Purpose: types of the serial configuration read-out block
// Assumes: constants come from cmsr_params.svh
// Notes:   mode encoding follows the read path in Gray order
`include "cmsr_params.svh"
package cmsr_pkg;
   typedef logic [`CMSR_ADDR_W-1:0] cmsr_addr_t;
   typedef enum logic [1:0] {
      CMSR_POR     = 2'b00,
      CMSR_READ    = 2'b01,
      CMSR_DONE    = 2'b11,
      CMSR_PROGRAM = 2'b10
   } cmsr_mode_t;
endpackage : cmsr_pkg

// ### core/cmsr_range_if.sv
// Purpose: carries the page window between top and range decoder
// Assumes: single clock domain
// Notes:   decoder drives first and last address
`timescale 1ns/1ps
interface cmsr_range_if;
   import cmsr_pkg::*;
   logic       page_enable;
   logic [1:0] page_select;
   cmsr_addr_t first_addr;
   cmsr_addr_t last_addr;
   modport ctrl (output page_enable, output page_select, input first_addr, input last_addr);
   modport dec  (input page_enable, input page_select, output first_addr, output last_addr);
endinterface : cmsr_range_if

// ### core/cmsr_range.sv
// Purpose: decodes the page window from page enable and select
// Assumes: inputs already synchronised
// Notes:   purely combinational
`timescale 1ns/1ps
`include "cmsr_params.svh"
module cmsr_range
   import cmsr_pkg::*;
(
   cmsr_range_if.dec rng
);
   wire cmsr_addr_t page_base;
   assign page_base = cmsr_addr_t'({rng.page_select, `CMSR_PAGE_SHIFT'(0)});
   // four equal pages or the whole array
   assign rng.first_addr = rng.page_enable ? page_base : '0;
   assign rng.last_addr  = rng.page_enable ? (page_base | `CMSR_PAGE_LAST) : `CMSR_FULL_LAST;
endmodule : cmsr_range

// ### core/cmsr_readout.sv
// Purpose: serial read-out of a configuration memory to a master-serial FPGA
// Assumes: serial_config_clock is this block's clk_sys; rst models power-up
// Notes:   array is a small flip-flop image indexed by low address bits
//
// Summary of operation
// - serial data output feeds FPGA data input
// - one bit moves per shared serial clock
// - cascade output drives next chip select
// - ready held low during power-on reset
// - last bit clock drives cascade low
// - same clock turns data driver off
// - low chip select enables downstream data
// - output enable low resets address counters
// - program mode low enters two-wire programming
// - standby when program mode and select high
// - standby keeps data output high impedance
// - four equal pages or whole space
// - output enable low clears counters
// - counting only with select low, enable high
// - cascade low held, then follows select
`timescale 1ns/1ps
`include "cmsr_params.svh"
module cmsr_readout
   import cmsr_pkg::*;
(
   // clock and power-up reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // control pins from the FPGA side
   input  wire logic       chip_select_n,
   input  wire logic       reset_oe,
   input  wire logic       program_mode_n,
   input  wire logic       page_enable,
   input  wire logic [1:0] page_select,
   // image load while programming
   input  wire logic       image_we,
   input  wire logic [5:0] image_idx,
   input  wire logic       image_bit,
   // serial outputs
   output logic            data_out,
   output logic            data_oe,
   output logic            cascade_out_n,
   output logic            ready_oe,
   output logic            ready_out,
   output logic            standby,
   output logic            programming
);
   // ==========================================================
   // pin synchronisers
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic [1:0] sel_a;
   logic [1:0] sel_b;
   always_ff @(posedge clk_sys) begin
      sync_a <= {chip_select_n, reset_oe, program_mode_n, page_enable, image_we};
      sync_b <= sync_a;
      sel_a  <= page_select;
      sel_b  <= sel_a;
   end
   wire logic cs_n_s;
   wire logic oe_s;
   wire logic pm_n_s;
   wire logic we_s;
   assign cs_n_s = sync_b[4];
   assign oe_s   = sync_b[3];
   assign pm_n_s = sync_b[2];
   assign we_s   = sync_b[0];

   // ==========================================================
   // page window
   cmsr_range_if rng ();
   assign rng.page_enable = sync_b[1];
   assign rng.page_select = sel_b;
   cmsr_range u_range (
      .rng (rng)
   );

   // ==========================================================
   // mode and power-on reset
   cmsr_mode_t mode;
   cmsr_mode_t next_mode;
   logic [`CMSR_POR_W-1:0] por_cnt;
   wire logic por_done;
   assign por_done = (por_cnt == `CMSR_POR_W'(`CMSR_POR_CYCLES - 1));
   always_ff @(posedge clk_sys) begin
      if (rst)
         por_cnt <= '0;
      else if (!por_done)
         por_cnt <= por_cnt + 1'b1;
   end

   cmsr_addr_t addr;
   wire logic active;
   wire logic at_last;
   wire logic step;
   wire logic wrap_ok;
   assign active  = (mode == CMSR_READ) && !cs_n_s && oe_s;
   assign at_last = (addr == rng.last_addr);
   assign step    = active;
   // oe low re-arms a finished part
   assign wrap_ok = !oe_s;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         CMSR_POR:     if (por_done) next_mode = pm_n_s ? CMSR_READ : CMSR_PROGRAM;
         CMSR_READ:    if (!pm_n_s) next_mode = CMSR_PROGRAM;
                       else if (step && at_last) next_mode = CMSR_DONE;
         CMSR_DONE:    if (!pm_n_s) next_mode = CMSR_PROGRAM;
                       else if (wrap_ok) next_mode = CMSR_READ;
         CMSR_PROGRAM: if (pm_n_s) next_mode = CMSR_READ;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst)
         mode <= CMSR_POR;
      else
         mode <= next_mode;
   end

   // ==========================================================
   // address counter
   // position held in done so oe high keeps it parked
   always_ff @(posedge clk_sys) begin
      if (rst)
         addr <= '0;
      else if (!oe_s || mode == CMSR_POR)
         addr <= rng.first_addr;
      else if (step && !at_last)
         addr <= addr + 1'b1;
   end

   // ==========================================================
   // image storage; flip-flops, small by design, upper address bits alias
   logic [`CMSR_MEM_DEPTH-1:0] image;
   logic [5:0] idx_a;
   logic [5:0] idx_b;
   logic       bit_a;
   logic       bit_b;
   always_ff @(posedge clk_sys) begin
      idx_a <= image_idx;
      idx_b <= idx_a;
      bit_a <= image_bit;
      bit_b <= bit_a;
   end
   genvar gi;
   generate
      for (gi = 0; gi < `CMSR_MEM_DEPTH; gi++) begin : g_cell
         always_ff @(posedge clk_sys) begin
            if (rst)
               image[gi] <= 1'b0;
            else if (mode == CMSR_PROGRAM && we_s && idx_b == 6'(gi))
               image[gi] <= bit_b;
         end
      end
   endgenerate
   wire logic [`CMSR_MEM_IDX_W-1:0] rd_idx;
   assign rd_idx = addr[`CMSR_MEM_IDX_W-1:0];

   // ==========================================================
   // outputs
   wire logic drive;
   wire logic in_standby;
   wire logic casc_low;
   wire logic next_data_out;
   wire logic next_data_oe;
   wire logic next_cascade_out_n;
   wire logic next_ready_oe;
   wire logic next_standby;
   wire logic next_programming;
   assign in_standby = pm_n_s && cs_n_s;
   // the last address still gets its own bit before the driver lets go
   assign drive      = active && pm_n_s;
   // low only once the last bit is out; then tracks select until oe drops
   assign casc_low   = (mode == CMSR_DONE) && oe_s && !cs_n_s;
   assign next_data_out      = drive ? image[rd_idx] : 1'b0;
   assign next_data_oe       = drive && !in_standby;
   assign next_cascade_out_n = !casc_low;
   assign next_ready_oe      = !por_done;
   assign next_standby       = in_standby;
   assign next_programming   = (next_mode == CMSR_PROGRAM);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_out      <= 1'b0;
         data_oe       <= 1'b0;
         cascade_out_n <= 1'b1;
         ready_oe      <= 1'b1;
         ready_out     <= 1'b0;
         standby       <= 1'b0;
         programming   <= 1'b0;
      end else begin
         data_out      <= next_data_out;
         data_oe       <= next_data_oe;
         cascade_out_n <= next_cascade_out_n;
         ready_oe      <= next_ready_oe;
         // open collector: level stays low, only the enable moves
         ready_out     <= 1'b0;
         standby       <= next_standby;
         programming   <= next_programming;
      end
   end

   // ==========================================================
   // checks: power-up and reset
   ready_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      !por_done |-> ##1 ready_oe)
      else $error("ready released early");

   ready_free_a: assert property (@(posedge clk_sys) disable iff (rst)
      por_done |-> ##1 (!ready_oe && !ready_out))
      else $error("ready held after power-up");

   power_clear_a: assert property (@(posedge clk_sys)
      rst |-> ##1 (addr == '0 && cascade_out_n))
      else $error("counter not cleared at power-up");

   // ==========================================================
   // checks: driver and standby
   stby_float_a: assert property (@(posedge clk_sys) disable iff (rst)
      in_standby |-> ##1 !data_oe)
      else $error("data driven in standby");

   stby_out_a: assert property (@(posedge clk_sys) disable iff (rst)
      in_standby |-> ##1 standby)
      else $error("standby not shown");

   read_start_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode == CMSR_READ && !cs_n_s && oe_s && pm_n_s) |-> ##1 data_oe)
      else $error("driver not enabled by select");

   oe_float_a: assert property (@(posedge clk_sys) disable iff (rst)
      !oe_s |-> ##1 !data_oe)
      else $error("data driven while oe low");

   prog_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!pm_n_s && mode != CMSR_POR) |-> ##1 (programming && !data_oe))
      else $error("programming mode not entered");

   // ==========================================================
   // checks: end of data and cascade
   last_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      (step && at_last && pm_n_s) |-> ##1 (data_oe && cascade_out_n))
      else $error("last bit not presented");

   casc_end_a: assert property (@(posedge clk_sys) disable iff (rst)
      (step && at_last && pm_n_s) ##1 (oe_s && !cs_n_s && pm_n_s) |-> ##1 (!cascade_out_n && !data_oe))
      else $error("end of data not signalled");

   casc_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode == CMSR_DONE && oe_s && pm_n_s) |-> ##1 (cascade_out_n == $past(cs_n_s)))
      else $error("cascade does not follow select");

   casc_rearm_a: assert property (@(posedge clk_sys) disable iff (rst)
      !oe_s |-> ##1 cascade_out_n)
      else $error("cascade low while oe low");

   // ==========================================================
   // checks: address counter
   oe_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!oe_s && mode != CMSR_POR) |-> ##1 (addr == $past(rng.first_addr)))
      else $error("counter not cleared");

   count_freeze_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cs_n_s && oe_s && mode != CMSR_POR) |-> ##1 $stable(addr))
      else $error("counter moved while deselected");

   step_up_a: assert property (@(posedge clk_sys) disable iff (rst)
      (active && !at_last) |-> ##1 (addr == $past(addr) + 1'b1))
      else $error("counter did not step");

   // ==========================================================
   // checks: page window
   page_top_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode == CMSR_READ |-> addr <= rng.last_addr)
      else $error("address past window");

   page_start_a: assert property (@(posedge clk_sys) disable iff (rst)
      rng.page_enable |-> (rng.first_addr[`CMSR_ADDR_W-1 -: 2] == rng.page_select &&
                           rng.first_addr[`CMSR_PAGE_SHIFT-1:0] == '0))
      else $error("page start wrong");

   page_span_a: assert property (@(posedge clk_sys) disable iff (rst)
      rng.page_enable |-> ((rng.last_addr - rng.first_addr) == `CMSR_PAGE_LAST))
      else $error("page span wrong");

   whole_span_a: assert property (@(posedge clk_sys) disable iff (rst)
      !rng.page_enable |-> (rng.first_addr == '0 && rng.last_addr == `CMSR_FULL_LAST))
      else $error("whole array window wrong");

   // ==========================================================
   // main scenarios
   por_cover_c:    cover property (@(posedge clk_sys) $rose(por_done));
   end_cover_c:    cover property (@(posedge clk_sys) $fell(cascade_out_n));
   prog_cover_c:   cover property (@(posedge clk_sys) $rose(programming));
   freeze_cover_c: cover property (@(posedge clk_sys) mode == CMSR_READ && cs_n_s && oe_s);
   rearm_cover_c:  cover property (@(posedge clk_sys) mode == CMSR_READ && !oe_s && !cs_n_s);
endmodule : cmsr_readout

// ### sim/cmsr_fpga_model.sv
// Purpose: master-serial loader standing on the far side of the read-out
// Assumes: one bit taken per rising serial clock while the memory drives
// Notes:   sampler only; chip select and output enable come from the bench
`timescale 1ns/1ps
module cmsr_fpga_model (
   // serial link
   input  wire logic         clk_sys,
   input  wire logic         data_in,
   input  wire logic         data_en,
   // capture control
   input  wire logic         clear,
   output logic [127:0]      bits,
   output logic [7:0]        count
);
   // =========================================
   // capture
   // stops at 128 bits so the early part of the stream stays put
   always_ff @(posedge clk_sys) begin
      if (clear) begin
         count <= 8'h00;
      end else if (data_en && count < 8'h80) begin
         bits[count[6:0]] <= data_in;
         count            <= count + 8'h01;
      end
   end
endmodule : cmsr_fpga_model

// ### sim/config_memory_serial_readout_tb.sv
// Purpose: self-checking bench of the serial configuration read-out
// Assumes: 100 ns serial clock; image aliases every 64 bits
// Notes:   page ends lie beyond the run length, so only starts are seen
`timescale 1ns/1ps
module config_memory_serial_readout_tb;
   import cmsr_pkg::*;
   logic         clk_sys = 1'b0;
   logic         rst = 1'b1, cs_n = 1'b1, reset_oe = 1'b0, pm_n = 1'b1, pe = 1'b0;
   logic [1:0]   ps = 2'h0;
   logic         we = 1'b0, ibit = 1'b0, clear = 1'b1;
   logic [5:0]   idx = 6'h00;
   logic         data_out, data_oe, cascade_out_n, ready_oe, ready_out, standby, programming;
   logic [127:0] bits;
   logic [7:0]   count;
   logic [63:0]  image;
   int           bad_count = 0;
   int           checks_done = 0;
   always #50 clk_sys = ~clk_sys;
   cmsr_readout dut (.clk_sys(clk_sys), .rst(rst), .chip_select_n(cs_n), .reset_oe(reset_oe),
      .program_mode_n(pm_n), .page_enable(pe), .page_select(ps), .image_we(we), .image_idx(idx),
      .image_bit(ibit), .data_out(data_out), .data_oe(data_oe), .cascade_out_n(cascade_out_n),
      .ready_oe(ready_oe), .ready_out(ready_out), .standby(standby), .programming(programming));
   cmsr_fpga_model fpga (.clk_sys(clk_sys), .data_in(data_out), .data_en(data_oe), .clear(clear),
      .bits(bits), .count(count));
   // =========================================
   // helpers
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task check(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // run of 64 bits from a start address; the image repeats every 64
   function automatic logic [63:0] exp_run(input logic [63:0] img, input int first);
      for (int k = 0; k < 64; k++)
         exp_run[k] = img[(first + k) % 64];
   endfunction : exp_run
   task restart;
      clear <= 1'b1;
      cyc(1);
      clear <= 1'b0;
   endtask : restart
   // bounded wait on the loader's bit count
   task wait_cnt(input int n);
      int i;
      for (i = 0; i < 300 && count < n; i++) @(posedge clk_sys);
      if (count < n) begin
         bad_count++;
         stop_test;
      end
   endtask : wait_cnt
   // =========================================
   // sequence
   initial begin
      int i;
      logic [7:0] held;
      void'($urandom(94));
      image = {$urandom, $urandom};
      cyc(5);
      rst <= 1'b0;
      cyc(2);
      check(ready_oe, 1'b1);
      for (i = 0; i < 20 && ready_oe !== 1'b0; i++) cyc(1);
      check(ready_oe, 1'b0);
      if (bad_count != 0) stop_test;
      check(ready_out, 1'b0);
      $display("test power-up done");
      pm_n <= 1'b0;
      // page pins settle while oe is low so the load picks the page start
      pe   <= 1'($urandom);
      ps   <= 2'($urandom);
      cyc(4);
      check(programming, 1'b1);
      check(data_oe, 1'b0);
      for (i = 0; i < 64; i++) begin
         we   <= 1'b1;
         idx  <= i[5:0];
         ibit <= image[i];
         cyc(1);
      end
      we       <= 1'b0;
      pm_n     <= 1'b1;
      reset_oe <= 1'b1;
      cyc(5);
      check(standby, 1'b1);
      check(data_oe, 1'b0);
      $display("test programming and standby done");
      cs_n <= 1'b0;
      restart;
      wait_cnt(40);
      cs_n <= 1'b1;
      cyc(6);
      held = count;
      cyc(3);
      check(data_oe, 1'b0);
      check(count, held);
      cs_n <= 1'b0;
      wait_cnt(100);
      check(bits[63:0], exp_run(image, 0));
      check(bits[99:64], image[35:0]);
      check(cascade_out_n, 1'b1);
      $display("test read with freeze done");
      reset_oe <= 1'b0;
      ps       <= 2'($urandom);
      cyc(4);
      check(data_oe, 1'b0);
      restart;
      reset_oe <= 1'b1;
      wait_cnt(64);
      check(bits[63:0], exp_run(image, 0));
      $display("test counter reset done");
      stop_test;
   end
endmodule : config_memory_serial_readout_tb
